// >>> hdl/rdpsc_pkg.sv
// Shared constants and types of the redriver power state control block
package rdpsc_pkg;

	localparam int CLK_PERIOD_NS = 25;

	// Sleep pin filter: must stay well under the 2 us sleep entry limit
	localparam int SLEEP_ENTRY_MAX_NS = 2000;
	localparam int SLEEP_FILT_NS = 1000;
	localparam int SLEEP_FILT_CYC_I = (SLEEP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] SLEEP_FILT_CYC = 6'(SLEEP_FILT_CYC_I);
	// Sleep exit to receiver detect limit
	localparam int WAKE_MAX_US = 100;

	// Selector debounce time
	localparam int SEL_STABLE_NS = 10000;
	localparam int SEL_STABLE_CYC_I = (SEL_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] SEL_STABLE_CYC = 9'(SEL_STABLE_CYC_I);

	// Receiver detect retry interval
	localparam int RETRY_MS = 12;
	localparam int RETRY_CYC = (RETRY_MS * 1000000) / CLK_PERIOD_NS;

	// Longest wait for the analog detector to report
	localparam int DET_TIMEOUT_NS = 5000;
	localparam int DET_TIMEOUT_CYC_I = DET_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [7:0] DET_TIMEOUT_CYC = 8'(DET_TIMEOUT_CYC_I);

	localparam int NUM_SEL = 6;
	localparam int SEL_SWING1 = 0;
	localparam int SEL_SWING2 = 1;
	localparam int SEL_EQ1 = 2;
	localparam int SEL_EQ2 = 3;
	localparam int SEL_DE1 = 4;
	localparam int SEL_DE2 = 5;

	typedef enum logic [1:0] {
		LVL_MID = 2'h0,
		LVL_LOW = 2'h1,
		LVL_HIGH = 2'h2
	} rdpsc_level_t;

	typedef enum logic [1:0] {
		ST_SLEEP = 2'h0,
		ST_DETECT = 2'h1,
		ST_LOWPWR = 2'h2,
		ST_NORMAL = 2'h3
	} rdpsc_state_t;

	typedef enum logic [1:0] {
		SW_1042MV = 2'h0,
		SW_908MV = 2'h1,
		SW_1127MV = 2'h2
	} rdpsc_swing_t;

	typedef enum logic [1:0] {
		EQ_0DB = 2'h0,
		EQ_7DB = 2'h1,
		EQ_15DB = 2'h2
	} rdpsc_eq_t;

	typedef enum logic [2:0] {
		DE_0DB = 3'h0,
		DE_M2P2DB = 3'h1,
		DE_M3P5DB = 3'h2,
		DE_M4P4DB = 3'h3,
		DE_M5P2DB = 3'h4,
		DE_M6P0DB = 3'h5
	} rdpsc_deemph_t;

	// Comparator pair of one three-level strap pin
	typedef struct packed {
		logic above_high;
		logic below_low;
	} rdpsc_tri_pin_t;

	typedef struct packed {
		rdpsc_tri_pin_t deemph_select_ch2;
		rdpsc_tri_pin_t deemph_select_ch1;
		rdpsc_tri_pin_t eq_select_ch2;
		rdpsc_tri_pin_t eq_select_ch1;
		rdpsc_tri_pin_t swing_select_ch2;
		rdpsc_tri_pin_t swing_select_ch1;
	} rdpsc_sel_pins_t;

	typedef struct packed {
		rdpsc_swing_t swing;
		rdpsc_eq_t eq;
		rdpsc_deemph_t deemph;
	} rdpsc_chan_cfg_t;

	typedef struct packed {
		logic rx_term_en;
		logic tx_drive_en;
		logic low_power;
	} rdpsc_chan_pwr_t;

endpackage

// >>> hdl/rdpsc_top.sv
// Strap decode and link power state machine of the two-channel redriver
//
// Overview of operation
// - A high sleep control level means normal running and a low level selects sleep.
// - Sleep follows a falling sleep control edge that stays low, or power-up with it low.
// - In sleep both terminations are high impedance and all signal activity stops.
// - Sleep entry completes within 2 us and exit to receiver detect takes at most 100 us.
// - A link break or a failed detection after power-up leads to receiver-detect mode.
// - In receiver-detect mode most circuitry is off and both input terminations float.
// - A reconnecting upstream device is sensed and normal operation resumes unaided.
// - Swing selector mid gives 1042 mVpp, low gives 908 mVpp and high gives 1127 mVpp.
// - Equalization selector mid gives 0 dB, low gives 7 dB and high gives 15 dB.
// - De-emphasis depends on both the channel's de-emphasis and swing selector levels.
// - All six selectors are three-level inputs decoded independently per channel.
// - Without a second swing pin, channel 2 swing is always the 1042 mVpp default.
// - After power-up or a sleep toggle, receive terminations float and detection runs.
// - Channels with no far-end termination go low power, transmitter off, retrying each 12 ms.
`timescale 1ns/1ps

module rdpsc_top #(
	parameter int unsigned RETRY_CYCLES = rdpsc_pkg::RETRY_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sleep_n,
	input wire rdpsc_pkg::rdpsc_sel_pins_t sel_pins,
	input wire logic no_swing_ch2_pin,
	input wire logic link_break,
	input wire logic rx_detect_done,
	input wire logic [1:0] rx_detect_found,
	output logic rx_detect_start,
	output rdpsc_pkg::rdpsc_state_t power_state,
	output logic core_enable,
	output rdpsc_pkg::rdpsc_chan_pwr_t [1:0] chan_pwr,
	output rdpsc_pkg::rdpsc_chan_cfg_t [1:0] chan_cfg
);
	import rdpsc_pkg::*;

	// Reset release through two flops
	logic [1:0] rst_sync;
	logic rst_n;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Sleep pin filter; reset level low so a low pin at power-up stays asleep
	logic sleep_lvl;
	logic next_sleep_lvl;
	logic [5:0] sleep_cnt;
	logic [5:0] next_sleep_cnt;

	always_comb begin
		next_sleep_lvl = sleep_lvl;
		next_sleep_cnt = 6'h0;
		if (sleep_n != sleep_lvl) begin
			if (sleep_cnt == SLEEP_FILT_CYC - 6'h1) begin
				next_sleep_lvl = sleep_n;
			end else begin
				next_sleep_cnt = sleep_cnt + 6'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_lvl <= 1'b0;
			sleep_cnt <= 6'h0;
		end else begin
			sleep_lvl <= next_sleep_lvl;
			sleep_cnt <= next_sleep_cnt;
		end
	end

	// Three-level selector debounce, one lane per pin
	rdpsc_tri_pin_t [NUM_SEL-1:0] pin_arr;
	rdpsc_level_t [NUM_SEL-1:0] sel_lvl;

	assign pin_arr = sel_pins;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SEL; gi++) begin : g_sel
			rdpsc_level_t raw;
			rdpsc_level_t cand;
			rdpsc_level_t next_cand;
			rdpsc_level_t stab;
			rdpsc_level_t next_stab;
			logic [8:0] cnt;
			logic [8:0] next_cnt;

			always_comb begin
				// Both comparators firing is impossible on a sane pin; treat as mid
				case ({pin_arr[gi].above_high, pin_arr[gi].below_low})
					2'b10: raw = LVL_HIGH;
					2'b01: raw = LVL_LOW;
					default: raw = LVL_MID;
				endcase
				next_cand = raw;
				next_stab = stab;
				next_cnt = 9'h0;
				if (raw == cand) begin
					if (cnt == SEL_STABLE_CYC - 9'h1) begin
						next_stab = cand;
						next_cnt = cnt;
					end else begin
						next_cnt = cnt + 9'h1;
					end
				end
			end

			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					cand <= LVL_MID;
					stab <= LVL_MID;
					cnt <= 9'h0;
				end else begin
					cand <= next_cand;
					stab <= next_stab;
					cnt <= next_cnt;
				end
			end

			assign sel_lvl[gi] = stab;
		end
	endgenerate

	// Setting decode per channel
	rdpsc_chan_cfg_t [1:0] next_cfg;
	rdpsc_level_t sw_lvl [2];

	always_comb begin
		sw_lvl[0] = sel_lvl[SEL_SWING1];
		sw_lvl[1] = no_swing_ch2_pin ? LVL_MID : sel_lvl[SEL_SWING2];
		for (int c = 0; c < 2; c++) begin
			case (sw_lvl[c])
				LVL_LOW: next_cfg[c].swing = SW_908MV;
				LVL_HIGH: next_cfg[c].swing = SW_1127MV;
				default: next_cfg[c].swing = SW_1042MV;
			endcase
			case (sel_lvl[SEL_EQ1 + c])
				LVL_LOW: next_cfg[c].eq = EQ_7DB;
				LVL_HIGH: next_cfg[c].eq = EQ_15DB;
				default: next_cfg[c].eq = EQ_0DB;
			endcase
			case ({sel_lvl[SEL_DE1 + c], sw_lvl[c]})
				{LVL_LOW, LVL_MID}: next_cfg[c].deemph = DE_M3P5DB;
				{LVL_LOW, LVL_LOW}: next_cfg[c].deemph = DE_M2P2DB;
				{LVL_LOW, LVL_HIGH}: next_cfg[c].deemph = DE_M4P4DB;
				{LVL_HIGH, LVL_MID}: next_cfg[c].deemph = DE_M6P0DB;
				{LVL_HIGH, LVL_LOW}: next_cfg[c].deemph = DE_M5P2DB;
				{LVL_HIGH, LVL_HIGH}: next_cfg[c].deemph = DE_M6P0DB;
				default: next_cfg[c].deemph = DE_0DB;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_cfg <= {2{SW_1042MV, EQ_0DB, DE_0DB}};
		end else begin
			chan_cfg <= next_cfg;
		end
	end

	// Link power state machine
	rdpsc_state_t state;
	rdpsc_state_t next_state;
	logic [1:0] found;
	logic [1:0] next_found;
	logic [19:0] wait_cnt;
	logic [19:0] next_wait_cnt;
	logic start;
	logic next_start;
	logic [7:0] det_cnt;
	logic [7:0] next_det_cnt;
	logic det_over;
	logic retry_due;

	assign det_over = rx_detect_done || det_cnt == DET_TIMEOUT_CYC;
	assign retry_due = wait_cnt == 20'(RETRY_CYCLES - 1);

	always_comb begin
		next_state = state;
		next_found = found;
		next_wait_cnt = 20'h0;
		next_det_cnt = 8'h0;
		next_start = 1'b0;
		case (state)
			ST_SLEEP: begin
				if (sleep_lvl) begin
					next_state = ST_DETECT;
					next_start = 1'b1;
				end
			end
			ST_DETECT: begin
				next_det_cnt = det_cnt + 8'h1;
				if (det_over && !start) begin
					next_found = rx_detect_done ? rx_detect_found : 2'h0;
					next_det_cnt = 8'h0;
					if (rx_detect_done && rx_detect_found == 2'h3) begin
						next_state = ST_NORMAL;
					end else begin
						next_state = ST_LOWPWR;
					end
				end
			end
			ST_LOWPWR: begin
				next_wait_cnt = wait_cnt + 20'h1;
				if (retry_due) begin
					next_state = ST_DETECT;
					next_start = 1'b1;
					next_wait_cnt = 20'h0;
				end
			end
			ST_NORMAL: begin
				if (link_break) begin
					next_state = ST_DETECT;
					next_start = 1'b1;
					next_found = 2'h0;
				end
			end
			default: begin
				next_state = ST_SLEEP;
			end
		endcase
		// Sleep overrides any pending move
		if (!sleep_lvl) begin
			next_state = ST_SLEEP;
			next_start = 1'b0;
			next_found = 2'h0;
			next_wait_cnt = 20'h0;
			next_det_cnt = 8'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_SLEEP;
			found <= 2'h0;
			wait_cnt <= 20'h0;
			start <= 1'b0;
			det_cnt <= 8'h0;
		end else begin
			state <= next_state;
			found <= next_found;
			wait_cnt <= next_wait_cnt;
			start <= next_start;
			det_cnt <= next_det_cnt;
		end
	end

	// Termination and power outputs, registered from the next state
	rdpsc_chan_pwr_t [1:0] next_pwr;
	logic next_core;

	always_comb begin
		next_core = 1'b0;
		for (int c = 0; c < 2; c++) begin
			next_pwr[c] = '{rx_term_en: 1'b0, tx_drive_en: 1'b0, low_power: 1'b1};
			case (next_state)
				ST_SLEEP: begin
					next_pwr[c] = '{rx_term_en: 1'b0, tx_drive_en: 1'b0, low_power: 1'b1};
				end
				ST_DETECT: begin
					// Transmitter stays up to sense the far end
					next_pwr[c] = '{rx_term_en: 1'b0, tx_drive_en: 1'b1, low_power: 1'b1};
				end
				ST_LOWPWR: begin
					next_pwr[c].rx_term_en = 1'b0;
					next_pwr[c].tx_drive_en = next_found[c];
					next_pwr[c].low_power = !next_found[c];
				end
				ST_NORMAL: begin
					next_pwr[c] = '{rx_term_en: 1'b1, tx_drive_en: 1'b1, low_power: 1'b0};
					next_core = 1'b1;
				end
				default: begin
					next_pwr[c] = '{rx_term_en: 1'b0, tx_drive_en: 1'b0, low_power: 1'b1};
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_pwr <= {2{1'b0, 1'b0, 1'b1}};
			core_enable <= 1'b0;
		end else begin
			chan_pwr <= next_pwr;
			core_enable <= next_core;
		end
	end

	assign rx_detect_start = start;
	assign power_state = state;

endmodule // rdpsc_top

// >>> verification/rdpsc_properties.sv
// Checker of power state and strap decode relations
`timescale 1ns/1ps
module rdpsc_properties
	import rdpsc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sleep_n,
	input wire logic no_swing_ch2_pin,
	input wire logic link_break,
	input wire logic rx_detect_done,
	input wire logic [1:0] rx_detect_found,
	input wire logic rx_detect_start,
	input wire rdpsc_state_t power_state,
	input wire logic core_enable,
	input wire rdpsc_chan_pwr_t [1:0] chan_pwr,
	input wire rdpsc_chan_cfg_t [1:0] chan_cfg
);
	logic [5:0] lo;
	logic [5:0] next_lo;
	logic det;
	// Saturating run length of low sleep pin samples
	always_comb next_lo = sleep_n ? 6'h0 : lo + {5'h0, lo != 6'h3f};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) lo <= 6'h0;
		else lo <= next_lo;
	end
	assign det = power_state == ST_DETECT && rx_detect_done && !rx_detect_start && sleep_n;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_core_normal: assert property (core_enable == (power_state == ST_NORMAL))
		else $error("core enable disagrees with state");
	chk_sleep_term: assert property (power_state == ST_SLEEP |-> chan_pwr == {2{3'h1}})
		else $error("terminations active in sleep");
	chk_sleep_entry: assert property (lo >= 6'h2c |-> power_state == ST_SLEEP)
		else $error("sleep not entered in time");
	chk_wake_detect: assert property ($past(power_state) == ST_SLEEP
		&& power_state != ST_SLEEP |-> power_state == ST_DETECT && rx_detect_start)
		else $error("sleep exit not into detection");
	chk_detect_rx_off: assert property (power_state == ST_DETECT
		|-> chan_pwr[0].rx_term_en == 1'b0 && chan_pwr[1].rx_term_en == 1'b0)
		else $error("input termination on in detection");
	chk_found_normal: assert property (det && rx_detect_found == 2'h3
		|=> power_state == ST_NORMAL)
		else $error("no normal after both found");
	chk_missing_low: assert property (det && rx_detect_found != 2'h3
		|=> power_state == ST_LOWPWR)
		else $error("no low power after missing end");
	chk_normal_terms: assert property (power_state == ST_NORMAL |-> chan_pwr == {2{3'h6}})
		else $error("terminations off in normal");
	chk_break_detect: assert property (power_state == ST_NORMAL && link_break
		&& sleep_n |=> power_state == ST_DETECT && rx_detect_start)
		else $error("link break not into detection");
	chk_swing2_fixed: assert property (no_swing_ch2_pin |=> chan_cfg[1].swing == SW_1042MV)
		else $error("channel 2 swing not default");
endmodule // rdpsc_properties
bind rdpsc_top rdpsc_properties chk (.clk(clk), .reset_n(reset_n), .sleep_n(sleep_n),
	.no_swing_ch2_pin(no_swing_ch2_pin), .link_break(link_break), .rx_detect_done(rx_detect_done),
	.rx_detect_found(rx_detect_found), .rx_detect_start(rx_detect_start),
	.power_state(power_state), .core_enable(core_enable), .chan_pwr(chan_pwr), .chan_cfg(chan_cfg));

// >>> verification/rdpsc_det_model.sv
// Far-end termination detector model answering detection requests
`timescale 1ns/1ps
module rdpsc_det_model (
	input wire logic clk,
	input wire logic start,
	input wire logic [1:0] far_term,
	input wire logic [3:0] lag,
	input wire logic mute,
	output logic done,
	output logic [1:0] found
);
	int cnt = -1;
	initial done = 1'b0;
	initial found = 2'h0;
	// Result only valid with done; inverted otherwise so nothing relies on it
	always @(posedge clk) begin
		done <= 1'b0;
		found <= ~found;
		// Muted far end never answers, so the design must time out
		if (start && !mute) cnt <= lag;
		else if (cnt > 0) cnt <= cnt - 1;
		else if (cnt == 0) begin
			done <= 1'b1;
			found <= far_term;
			cnt <= -1;
		end
	end
endmodule // rdpsc_det_model

// >>> verification/rdpsc_top_tb.sv
// Self-checking bench of the redriver power state control block
`timescale 1ns/1ps
module rdpsc_top_tb;
	import rdpsc_pkg::*;
	localparam int RETRY = 50;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic sleep_n = 1'b1;
	rdpsc_sel_pins_t sel_pins = '0;
	logic no_swing_ch2_pin = 1'b0;
	logic link_break = 1'b0;
	logic [1:0] far_term = 2'h3;
	logic [3:0] lag = 4'h2;
	logic mute = 1'b0;
	logic rx_detect_done;
	logic [1:0] rx_detect_found;
	logic rx_detect_start;
	rdpsc_state_t power_state;
	logic core_enable;
	rdpsc_chan_pwr_t [1:0] chan_pwr;
	rdpsc_chan_cfg_t [1:0] chan_cfg;
	int fail_count = 0;
	int checked = 0;
	int n;
	int lv [6];
	logic [31:0] seed = 32'hed5b;
	rdpsc_deemph_t de_tab [3][3] = '{'{DE_0DB, DE_0DB, DE_0DB},
		'{DE_M3P5DB, DE_M2P2DB, DE_M4P4DB}, '{DE_M6P0DB, DE_M5P2DB, DE_M6P0DB}};
	always #12.5 clk = ~clk;
	rdpsc_top #(.RETRY_CYCLES(RETRY)) DUT (.clk(clk), .reset_n(reset_n), .sleep_n(sleep_n),
		.sel_pins(sel_pins), .no_swing_ch2_pin(no_swing_ch2_pin), .link_break(link_break),
		.rx_detect_done(rx_detect_done), .rx_detect_found(rx_detect_found),
		.rx_detect_start(rx_detect_start), .power_state(power_state),
		.core_enable(core_enable), .chan_pwr(chan_pwr), .chan_cfg(chan_cfg));
	rdpsc_det_model far_end (.clk(clk), .start(rx_detect_start), .far_term(far_term),
		.lag(lag), .mute(mute), .done(rx_detect_done), .found(rx_detect_found));
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	function automatic logic [6:0] exp_cfg(int s, int e, int d);
		return {2'(s), 2'(e), 3'(de_tab[d][s])};
	endfunction
	task report_and_stop();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task chk(string name, logic [31:0] e, logic [31:0] s);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, e, s);
		end
	endtask
	task wait_st(rdpsc_state_t st, int lim, output int cnt);
		for (cnt = 0; cnt < lim && power_state !== st; cnt++) @(negedge clk);
		chk("power_state", st, power_state);
		if (power_state !== st) report_and_stop();
	endtask
	initial begin
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		chk("power_state", ST_SLEEP, power_state);
		chk("chan_cfg", 14'h0, chan_cfg);
		wait_st(ST_NORMAL, 300, n);
		chk("core_enable", 1, core_enable);
		$display("test wake done");
		lag = 4'hc;
		far_term = 2'h2;
		link_break = 1'b1;
		@(negedge clk);
		link_break = 1'b0;
		wait_st(ST_LOWPWR, 300, n);
		chk("chan_pwr", {3'h2, 3'h1}, chan_pwr);
		far_term = 2'h3;
		wait_st(ST_DETECT, RETRY + 5, n);
		chk("retry wait", RETRY, n);
		wait_st(ST_NORMAL, 300, n);
		$display("test link break done");
		mute = 1'b1;
		link_break = 1'b1;
		@(negedge clk);
		link_break = 1'b0;
		wait_st(ST_LOWPWR, 300, n);
		chk("detect timeout", 1, n >= DET_TIMEOUT_CYC_I && n <= DET_TIMEOUT_CYC_I + 1);
		chk("chan_pwr", {2{3'h1}}, chan_pwr);
		mute = 1'b0;
		wait_st(ST_NORMAL, 300, n);
		$display("test detect timeout done");
		sleep_n = 1'b0;
		repeat (20) @(negedge clk);
		sleep_n = 1'b1;
		repeat (60) @(negedge clk);
		chk("power_state", ST_NORMAL, power_state);
		sleep_n = 1'b0;
		wait_st(ST_SLEEP, 80, n);
		chk("chan_pwr", {2{3'h1}}, chan_pwr);
		sleep_n = 1'b1;
		wait_st(ST_DETECT, 4000, n);
		$display("test sleep done");
		for (int i = 0; i < 9; i++) begin
			seed = xs(seed);
			lv = '{i % 3, i / 3, seed[3:0] % 3, seed[7:4] % 3, i / 3, i % 3};
			for (int j = 0; j < 6; j++)
				sel_pins[2 * j +: 2] = lv[j] == 0 ? {2{seed[j + 8]}} : 2'(lv[j]);
			no_swing_ch2_pin = seed[16];
			repeat (420) @(negedge clk);
			chk("chan_cfg ch1", exp_cfg(lv[0], lv[2], lv[4]), chan_cfg[0]);
			n = no_swing_ch2_pin ? 0 : lv[1];
			chk("chan_cfg ch2", exp_cfg(n, lv[3], lv[5]), chan_cfg[1]);
		end
		sel_pins[0] = ~sel_pins[0];
		repeat (100) @(negedge clk);
		chk("chan_cfg bounce", exp_cfg(lv[0], lv[2], lv[4]), chan_cfg[0]);
		sel_pins[0] = ~sel_pins[0];
		repeat (420) @(negedge clk);
		chk("chan_cfg ch1", exp_cfg(lv[0], lv[2], lv[4]), chan_cfg[0]);
		$display("test strap decode done");
		sleep_n = 1'b0;
		reset_n = 1'b0;
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		repeat (100) @(negedge clk);
		chk("power_state", ST_SLEEP, power_state);
		$display("test power-up asleep done");
		report_and_stop();
	end
endmodule // rdpsc_top_tb
